// *** design/exc_entry.sv ***
// Exception entry for the external interrupt and the alignment exception.
// Assumes the core presents the history-buffer head and memory accesses on
// SYS_CLK; the interrupt request pins come from outside and are synchronised.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Hold off external interrupt when blocked or disabled
// - Any taken exception clears ext_irq_enable
// - Retire ready instructions, attach to head
// - Enhanced mode splits 0x500 into 48 vectors
// - Hardware masks lower-priority nested sources
// - save_restore_pc gets next instruction address
// - Save state: high-order half cleared, low-order copied
// - Bit 30 copied to save state, cleared in machine state on entry
// - Keep base and check bits, swap byte order
// - Decompression flag is AND of config bits
// - Compressed fetch saves compressed-format address
// - Interrupt fetch resumes at base plus 0x500
// - Misaligned fp, multiple, reserve raises 0x600
// - Alignment saves state, records fault cause
module exc_entry #(
  parameter int NUM_SOURCES = exc_entry_pkg::MAX_SOURCES
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RESET,
  input  wire logic                          EXT_IRQ,
  input  wire logic [NUM_SOURCES-1:0]        IRQ_SOURCES,
  input  wire logic                          ENHANCED_MODE,
  input  wire logic                          HIGHER_EXC_BUSY,
  input  wire exc_entry_pkg::retire_head_type RETIRE_HEAD,
  input  wire exc_entry_pkg::mem_access_type  MEM_ACCESS,
  input  wire exc_entry_pkg::burst_cfg_type   BURST_CFG,
  input  wire logic                          MSR_WRITE,
  input  wire logic [31:0]                   MSR_WDATA,
  input  wire logic                          HANDLER_DONE,
  output logic [31:0]                        MACHINE_STATE,
  output logic [31:0]                        SAVE_PC,
  output logic [31:0]                        SAVE_STATE,
  output logic [31:0]                        FAULT_SOURCE,
  output logic                               REDIRECT,
  output logic [31:0]                        REDIRECT_PC,
  output logic                               RETIRE_FLUSH,
  output logic [5:0]                         ACTIVE_LEVEL
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NUM_SOURCES < 1 || NUM_SOURCES > exc_entry_pkg::MAX_SOURCES) begin :
      g_bad_sources
    $error("NUM_SOURCES must lie between 1 and 48.");
  end

  // The idle level must lie above every source number. Otherwise the
  // lowest-priority source could never be taken from idle.
  if (exc_entry_pkg::LEVEL_NONE < NUM_SOURCES) begin : g_bad_level
    $error("The idle nesting level must exceed every source number.");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic                   irq_meta_reg;
  logic                   irq_sync_reg;
  logic [NUM_SOURCES-1:0] src_meta_reg;
  logic [NUM_SOURCES-1:0] src_sync_reg;

  // Pins come from outside the clock domain, so two flops before any use.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      irq_meta_reg <= EXT_IRQ;
      irq_sync_reg <= irq_meta_reg;
      src_meta_reg <= IRQ_SOURCES;
      src_sync_reg <= src_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Enhanced-mode source selection
  // ----------------------------------------------------------------------
  logic [31:0] msr_reg;
  logic [5:0]  level_reg;
  logic [5:0]  best_level;
  logic        best_found;
  logic [NUM_SOURCES-1:0] src_allowed;

  // level masking: source 0 is the highest priority, and only a source
  // numbered below the one being serviced may nest.
  for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_mask
    assign src_allowed[i] = src_sync_reg[i] && (6'(i) < level_reg);
  end

  // Lowest-numbered allowed source wins; searched from the top down.
  always_comb begin
    best_level = exc_entry_pkg::LEVEL_NONE;
    best_found = 1'b0;
    for (int k = NUM_SOURCES - 1; k >= 0; k--) begin
      if (src_allowed[k]) begin
        best_level = 6'(k);
        best_found = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decision of which exception is taken
  // ----------------------------------------------------------------------
  logic                       ext_pending;
  logic                       ext_allowed;
  logic                       align_fault;
  logic [3:0]                 align_cause;
  exc_entry_pkg::take_type    take;

  assign ext_pending = ENHANCED_MODE ? best_found : irq_sync_reg;

  // hold off: enable bit set and no higher exception underway.
  // head attach: only once the head instruction is ready to retire.
  assign ext_allowed = ext_pending && !HIGHER_EXC_BUSY &&
                       msr_reg[31 - exc_entry_pkg::EXT_IRQ_ENABLE_BIT] &&
                       RETIRE_HEAD.valid && RETIRE_HEAD.ready_to_retire;

  // alignment check: word alignment means the low two bits are zero.
  // An access that carries no access flag is never checked, whatever its address.
  assign align_fault = (MEM_ACCESS.address[1:0] != 2'b00) &&
                       (MEM_ACCESS.fp_access || MEM_ACCESS.multiple_access ||
                        MEM_ACCESS.reserve_access);

  assign align_cause =
      (MEM_ACCESS.fp_access       ? exc_entry_pkg::ALIGN_CAUSE_FP   : 4'h0) |
      (MEM_ACCESS.multiple_access ? exc_entry_pkg::ALIGN_CAUSE_MULT : 4'h0) |
      (MEM_ACCESS.reserve_access  ? exc_entry_pkg::ALIGN_CAUSE_RSV  : 4'h0);

  // fixed order: the synchronous alignment fault outranks the
  // interrupt, which is not lost but waits until the enable bit is set again.
  always_comb begin
    if (align_fault && !HIGHER_EXC_BUSY) begin
      take = exc_entry_pkg::TAKE_ALIGN;
    end else if (ext_allowed) begin
      take = exc_entry_pkg::TAKE_EXT;
    end else begin
      take = exc_entry_pkg::TAKE_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Entry values
  // ----------------------------------------------------------------------
  logic [31:0] msr_next;
  logic [31:0] save_state_next;
  logic [31:0] base_addr;
  logic [31:0] vector_next;

  // base select picks the high or the low physical base.
  assign base_addr = msr_reg[31 - exc_entry_pkg::VECTOR_BASE_BIT] ?
                     exc_entry_pkg::BASE_HIGH : exc_entry_pkg::BASE_LOW;

  // state save, and bit 30 only ever follows the copied bit.
  assign save_state_next = {16'h0000, msr_reg[15:0]};

  // state update and decompression flag; enable cleared since
  // every other bit starts from zero.
  always_comb begin
    msr_next = exc_entry_pkg::MSR_RESET;
    msr_next[31 - exc_entry_pkg::VECTOR_BASE_BIT] =
        msr_reg[31 - exc_entry_pkg::VECTOR_BASE_BIT];
    msr_next[31 - exc_entry_pkg::MACHINE_CHECK_BIT] =
        msr_reg[31 - exc_entry_pkg::MACHINE_CHECK_BIT];
    // Exception byte order itself starts from zero like the other bits;
    // only its old value survives, moved into byte_order_mode.
    msr_next[31 - exc_entry_pkg::BYTE_ORDER_MODE_BIT] =
        msr_reg[31 - exc_entry_pkg::BYTE_ORDER_EXC_BIT];
    msr_next[31 - exc_entry_pkg::DECOMP_ENABLE_BIT] =
        BURST_CFG.compression_enable && BURST_CFG.exception_compression;
  end

  // vector split: each enhanced source has its own 0x10 slot, source 0 at 0x500.
  always_comb begin
    if (take == exc_entry_pkg::TAKE_ALIGN) begin
      vector_next = base_addr | exc_entry_pkg::ALIGN_OFFSET;
    end else if (ENHANCED_MODE) begin
      vector_next = base_addr + exc_entry_pkg::EXT_IRQ_OFFSET +
                    32'(best_level) * exc_entry_pkg::VECTOR_STRIDE;
    end else begin
      vector_next = base_addr | exc_entry_pkg::EXT_IRQ_OFFSET;
    end
  end

  // ----------------------------------------------------------------------
  // Machine state register
  // ----------------------------------------------------------------------
  // enable cleared: entry wins over a software write in the same cycle.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      msr_reg <= exc_entry_pkg::MSR_RESET;
    end else if (take != exc_entry_pkg::TAKE_NONE) begin
      msr_reg <= msr_next;
    end else if (MSR_WRITE) begin
      msr_reg <= MSR_WDATA;
    end
  end

  // ----------------------------------------------------------------------
  // Save and restore registers, fault source
  // ----------------------------------------------------------------------
  logic [31:0] save_pc_reg;
  logic [31:0] save_state_reg;
  logic [31:0] fault_reg;

  // next address and compressed form when fetch is compressed.
  // alignment save uses the same pair of registers.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      save_pc_reg    <= exc_entry_pkg::WORD_RESET;
      save_state_reg <= exc_entry_pkg::WORD_RESET;
    end else if (take != exc_entry_pkg::TAKE_NONE) begin
      save_pc_reg    <= RETIRE_HEAD.compressed ? RETIRE_HEAD.compressed_pc :
                        RETIRE_HEAD.next_pc;
      save_state_reg <= save_state_next;
    end
  end

  // cause record: the kind of access lands in the low nibble.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fault_reg <= exc_entry_pkg::WORD_RESET;
    end else if (take == exc_entry_pkg::TAKE_ALIGN) begin
      fault_reg <= {28'h000_0000, align_cause};
    end
  end

  // ----------------------------------------------------------------------
  // Nesting level and redirect
  // ----------------------------------------------------------------------
  // nesting: the level falls to the source number on enhanced-mode interrupt entry and goes back to idle on handler exit.
  // Only one level is remembered, so deeper return needs software help.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      level_reg <= exc_entry_pkg::LEVEL_NONE;
    end else if (take == exc_entry_pkg::TAKE_EXT && ENHANCED_MODE) begin
      level_reg <= best_level;
    end else if (HANDLER_DONE) begin
      level_reg <= exc_entry_pkg::LEVEL_NONE;
    end
  end

  logic        redirect_reg;
  logic [31:0] redirect_pc_reg;
  logic        flush_reg;

  // retire then flush: the work behind the head is discarded in the
  // cycle after entry, together with the redirect.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= (take != exc_entry_pkg::TAKE_NONE);
    end
  end

  // fetch restart: a one-cycle pulse that fetch follows at once.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      redirect_reg <= 1'b0;
    end else begin
      redirect_reg <= (take != exc_entry_pkg::TAKE_NONE);
    end
  end

  // vector: held until the next entry, so that a late reader
  // of the target still finds it.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      redirect_pc_reg <= exc_entry_pkg::WORD_RESET;
    end else if (take != exc_entry_pkg::TAKE_NONE) begin
      redirect_pc_reg <= vector_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a register copy, so nothing combinational reaches a pin.
  assign MACHINE_STATE = msr_reg;
  assign SAVE_PC       = save_pc_reg;
  assign SAVE_STATE    = save_state_reg;
  assign FAULT_SOURCE  = fault_reg;
  assign REDIRECT      = redirect_reg;
  assign REDIRECT_PC   = redirect_pc_reg;
  assign RETIRE_FLUSH  = flush_reg;
  assign ACTIVE_LEVEL  = level_reg;

endmodule

`default_nettype wire

// *** design/exc_entry_pkg.sv ***
// Package for the exception-entry block: bit positions, vector offsets,
// reset values and the carrier structs.
// Assumes big-endian bit numbering of 32-bit state words (bit 0 = MSB).
package exc_entry_pkg;

  // ----------------------------------------------------------------------
  // Machine state bit positions (big-endian numbering, bit 0 is the MSB)
  // ----------------------------------------------------------------------
  localparam int EXT_IRQ_ENABLE_BIT   = 16;
  localparam int BYTE_ORDER_EXC_BIT   = 15;
  localparam int VECTOR_BASE_BIT      = 25;
  localparam int MACHINE_CHECK_BIT    = 19;
  localparam int DECOMP_ENABLE_BIT    = 29;
  localparam int RECOVERABLE_BIT      = 30;
  localparam int BYTE_ORDER_MODE_BIT  = 31;

  // ----------------------------------------------------------------------
  // Vectors, sizes and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] EXT_IRQ_OFFSET   = 32'h0000_0500;
  localparam logic [31:0] ALIGN_OFFSET     = 32'h0000_0600;
  localparam logic [31:0] BASE_HIGH        = 32'hFFF0_0000;
  localparam logic [31:0] BASE_LOW         = 32'h0000_0000;
  localparam logic [31:0] MSR_RESET        = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
  localparam logic [31:0] VECTOR_STRIDE    = 32'h0000_0010;
  localparam int          MAX_SOURCES      = 48;
  localparam int          LEVEL_BITS       = 6;
  localparam logic [5:0]  LEVEL_NONE       = 6'h3F;
  localparam logic [3:0]  ALIGN_CAUSE_FP   = 4'h1;
  localparam logic [3:0]  ALIGN_CAUSE_MULT = 4'h2;
  localparam logic [3:0]  ALIGN_CAUSE_RSV  = 4'h4;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] next_pc;
    logic        compressed;
    logic [31:0] compressed_pc;
    logic        ready_to_retire;
  } retire_head_type;

  typedef struct packed {
    logic        fp_access;
    logic        multiple_access;
    logic        reserve_access;
    logic [31:0] address;
  } mem_access_type;

  typedef struct packed {
    logic        compression_enable;
    logic        exception_compression;
  } burst_cfg_type;

  typedef enum logic [1:0] {
    TAKE_NONE,
    TAKE_ALIGN,
    TAKE_EXT
  } take_type;

endpackage

// *** testbench/exc_entry_assertions.sv ***
// Checker for the exception-entry block, watching top-level ports only.
// Assumes one clock domain and the synchronous active-high RESET.
`timescale 1ns/1ps
`default_nettype none
module exc_entry_assertions (
  input wire logic                          SYS_CLK,
  input wire logic                          RESET,
  input wire logic                          HIGHER_EXC_BUSY,
  input wire logic                          ENHANCED_MODE,
  input wire exc_entry_pkg::mem_access_type MEM_ACCESS,
  input wire exc_entry_pkg::burst_cfg_type  BURST_CFG,
  input wire logic [31:0]                   MACHINE_STATE,
  input wire logic [31:0]                   SAVE_STATE,
  input wire logic                          REDIRECT,
  input wire logic [31:0]                   REDIRECT_PC,
  input wire logic                          RETIRE_FLUSH
);
  // ------------------------------------------------------------
  // Helper logic and properties
  // ------------------------------------------------------------
  logic bad;
  logic [31:0] base;
  // A misaligned access; it outranks any pending interrupt.
  assign bad = (MEM_ACCESS.fp_access || MEM_ACCESS.multiple_access ||
                MEM_ACCESS.reserve_access) && MEM_ACCESS.address[1:0] != 0;
  // Vector base chosen by machine state bit 6 (vector_base_select).
  assign base = MACHINE_STATE[6] ? exc_entry_pkg::BASE_HIGH :
                exc_entry_pkg::BASE_LOW;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_busy_blocks_entry: assert property (
    HIGHER_EXC_BUSY |=> !REDIRECT) else $error("entry while busy");
  a_disabled_no_entry: assert property (
    !MACHINE_STATE[15] && !bad |=> !REDIRECT) else $error("entry disabled");
  a_entry_clears_enable: assert property (
    REDIRECT |-> !MACHINE_STATE[15]) else $error("enable left set");
  a_flush_with_redirect: assert property (
    REDIRECT == RETIRE_FLUSH) else $error("flush not paired");
  a_save_state_split: assert property (
    REDIRECT |-> SAVE_STATE == {16'h0000, $past(MACHINE_STATE[15:0])})
    else $error("saved state wrong");
  a_msr_entry_value: assert property (
    REDIRECT |-> MACHINE_STATE == (($past(MACHINE_STATE) & 32'h0000_1040)
      | {31'h0000_0000, $past(MACHINE_STATE[16])} | ($past(BURST_CFG) ==
      2'h3 ? 32'h0000_0004 : 32'h0000_0000))) else $error("state wrong");
  a_align_vector_taken: assert property (
    bad && !HIGHER_EXC_BUSY |=> REDIRECT && REDIRECT_PC ==
    $past(base) + exc_entry_pkg::ALIGN_OFFSET) else $error("align vector");
  a_ext_vector_base: assert property (
    REDIRECT && !$past(bad) && !$past(ENHANCED_MODE) |-> REDIRECT_PC ==
    $past(base) + exc_entry_pkg::EXT_IRQ_OFFSET) else $error("ext vector");
endmodule
`default_nettype wire

// *** testbench/exc_entry_bench.sv ***
// Self-checking bench for the exception-entry block.
// Assumes the interrupt source model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module exc_entry_bench;
  // ------------------------------------------------------------
  // Signals, design and partner
  // ------------------------------------------------------------
  logic SYS_CLK, RESET, EXT_IRQ, ENHANCED_MODE, HIGHER_EXC_BUSY;
  logic MSR_WRITE, HANDLER_DONE, REDIRECT, RETIRE_FLUSH, raise, drop;
  logic [47:0] IRQ_SOURCES;
  logic [31:0] MSR_WDATA, MACHINE_STATE, SAVE_PC, SAVE_STATE;
  logic [31:0] FAULT_SOURCE, REDIRECT_PC;
  logic [5:0]  ACTIVE_LEVEL, src;
  exc_entry_pkg::retire_head_type RETIRE_HEAD;
  exc_entry_pkg::mem_access_type  MEM_ACCESS;
  exc_entry_pkg::burst_cfg_type   BURST_CFG;
  int num_errors, n_checks;
  exc_entry exc_entry_inst (.SYS_CLK, .RESET, .EXT_IRQ, .IRQ_SOURCES,
    .ENHANCED_MODE, .HIGHER_EXC_BUSY, .RETIRE_HEAD, .MEM_ACCESS, .BURST_CFG,
    .MSR_WRITE, .MSR_WDATA, .HANDLER_DONE, .MACHINE_STATE, .SAVE_PC,
    .SAVE_STATE, .FAULT_SOURCE, .REDIRECT, .REDIRECT_PC, .RETIRE_FLUSH,
    .ACTIVE_LEVEL);
  irq_source_model irq_source_model_inst (.clk(SYS_CLK), .raise, .src,
    .drop, .ext_irq(EXT_IRQ), .sources(IRQ_SOURCES));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic machine_state_reg(input logic [31:0] v);
    @(posedge SYS_CLK) begin MSR_WRITE <= 1'b1; MSR_WDATA <= v; end
    @(posedge SYS_CLK) MSR_WRITE <= 1'b0;
  endtask
  task automatic fire(input logic [5:0] s);
    @(posedge SYS_CLK) begin raise <= 1'b1; src <= s; end
    @(posedge SYS_CLK) raise <= 1'b0;
  endtask
  task automatic release_irq();
    @(posedge SYS_CLK) drop <= 1'b1;
    @(posedge SYS_CLK) drop <= 1'b0;
  endtask
  // A bound that runs out is a hang: count it and close the run.
  task automatic expect_entry();
    int i;
    for (i = 0; i < 10; i++) begin
      @(posedge SYS_CLK);
      #1;
      if (REDIRECT === 1'b1) break;
    end
    if (REDIRECT !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic expect_none(input int n);
    repeat (n) begin @(posedge SYS_CLK); #1; chk("no entry", 0, 32'(REDIRECT)); end
  endtask
  // One-cycle access; the entry shows on the following cycle.
  task automatic access(input exc_entry_pkg::mem_access_type v);
    @(posedge SYS_CLK) begin HIGHER_EXC_BUSY <= 1'b0; MEM_ACCESS <= v; end
    @(posedge SYS_CLK) MEM_ACCESS <= '0;
    #1;
  endtask
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin SYS_CLK = 1'b0; forever #50 SYS_CLK = ~SYS_CLK; end
  initial begin
    {RESET, ENHANCED_MODE, HIGHER_EXC_BUSY, MSR_WRITE} = 4'h8;
    {HANDLER_DONE, raise, drop, src, MSR_WDATA, MEM_ACCESS} = '0;
    drop = 1'b1; // Clears the model's request levels during reset.
    RETIRE_HEAD = '{1'b1, 32'h0000_1234, 1'b0, 32'h0000_0246, 1'b1};
    BURST_CFG = 2'h3;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge SYS_CLK);
    RESET <= 1'b0;
    drop <= 1'b0;
    #1;
    chk("reset level", 32'h0000_003F, 32'(ACTIVE_LEVEL));
    chk("reset state", 32'h0000_0000, MACHINE_STATE);
    machine_state_reg(32'h0001_9242);
    fire(0);
    expect_entry();
    chk("vector", 32'hFFF0_0500, REDIRECT_PC);
    chk("save pc", 32'h0000_1234, SAVE_PC);
    chk("save state", 32'h0000_9242, SAVE_STATE);
    chk("state", 32'h0000_1045, MACHINE_STATE);
    chk("flush", 1, 32'(RETIRE_FLUSH));
    release_irq();
    fire(0);
    expect_none(8);
    HIGHER_EXC_BUSY <= 1'b1;
    RETIRE_HEAD.compressed <= 1'b1;
    BURST_CFG <= 2'h0;
    machine_state_reg(32'h0000_8000);
    expect_none(6);
    HIGHER_EXC_BUSY <= 1'b0;
    expect_entry();
    chk("vector", 32'h0000_0500, REDIRECT_PC);
    chk("save pc", 32'h0000_0246, SAVE_PC);
    chk("save state", 32'h0000_8000, SAVE_STATE);
    release_irq();
    for (int k = 0; k < 3; k++) begin
      access('{k == 0, k == 1, k == 2, 32'h0000_2002});
      chk("align", 32'h0000_0600, REDIRECT_PC);
      chk("align entry", 1, 32'(REDIRECT));
      chk("cause", 32'(1 << k), 32'(FAULT_SOURCE[3:0]));
    end
    access('{1'b1, 1'b0, 1'b0, 32'h0000_2000});
    chk("aligned", 0, 32'(REDIRECT));
    HIGHER_EXC_BUSY <= 1'b1;
    machine_state_reg(32'h0000_8000);
    fire(0);
    repeat (4) @(posedge SYS_CLK);
    access('{1'b0, 1'b1, 1'b0, 32'h0000_2001});
    chk("first", 32'h0000_0600, REDIRECT_PC);
    expect_none(6);
    release_irq();
    ENHANCED_MODE <= 1'b1;
    machine_state_reg(32'h0000_8000);
    fire(3);
    expect_entry();
    chk("source vector", 32'h0000_0530, REDIRECT_PC);
    chk("level", 3, 32'(ACTIVE_LEVEL));
    release_irq();
    machine_state_reg(32'h0000_8000);
    fire(5);
    expect_none(6);
    fire(1);
    expect_entry();
    chk("source vector", 32'h0000_0510, REDIRECT_PC);
    release_irq();
    @(posedge SYS_CLK) HANDLER_DONE <= 1'b1;
    @(posedge SYS_CLK) HANDLER_DONE <= 1'b0;
    #1;
    chk("level", 32'h0000_003F, 32'(ACTIVE_LEVEL));
    conclude();
  end
endmodule
bind exc_entry exc_entry_assertions exc_entry_assertions_inst (.SYS_CLK,
  .RESET, .HIGHER_EXC_BUSY, .ENHANCED_MODE, .MEM_ACCESS, .BURST_CFG,
  .MACHINE_STATE, .SAVE_STATE, .REDIRECT, .REDIRECT_PC, .RETIRE_FLUSH);
`default_nettype wire

// *** testbench/irq_source_model.sv ***
// Interrupt source model: latches requests per source until dropped.
// Assumes the bench raises and drops requests on the same clock.
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  input  wire logic        clk,
  input  wire logic        raise,
  input  wire logic [5:0]  src,
  input  wire logic        drop,
  output logic             ext_irq,
  output logic [47:0]      sources
);
  // ------------------------------------------------------------
  // Request levels
  // ------------------------------------------------------------
  logic [47:0] pend_reg;
  // one line per source
  // Levels stay up until dropped, as a real controller would hold them.
  always_ff @(posedge clk) begin
    if (drop) begin
      pend_reg <= 48'h0000_0000_0000;
    end else if (raise) begin
      pend_reg[src] <= 1'b1;
    end
  end
  assign sources = pend_reg;
  assign ext_irq = |pend_reg;
endmodule
`default_nettype wire
